// *** sink_id_and_overflow_status_regs.sv ***
// Contract
// (RL1) Identity word holds major, minor, revision bytes
// (RL2) Low identity byte reads receive mode one
// (RL3) Identity word is read-only, writes ignored
// (RL4) Overrun register reports pixel FIFO overflows
// (RL5) Bits 0-3 flag stream 1-4 pixel overflow
// (RL6) Pixel overflow flags stick until read
// (RL7) Bits 4-6 flag unpack FIFO overflow
// (RL8) Bits 9-11 flag timing FIFO overflow
// (RL9) Vsync register shows live sync, streams 1-4
// (RL10) Undefined bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module sink_id_and_overflow_status_regs #(
  parameter logic [7:0] PROTO_MAJOR = 8'h01,  // Arbitrary default
  parameter logic [7:0] PROTO_MINOR = 8'h00,  // Arbitrary default
  parameter logic [7:0] PROTO_REV   = 8'h00   // Arbitrary default
) (
  input  wire logic                                 CLOCK,
  input  wire logic                                 RST,
  input  wire logic                                 HSEL,
  input  wire logic [31:0]                          HADDR,
  input  wire logic [1:0]                           HTRANS,
  input  wire logic                                 HWRITE,
  input  wire logic [2:0]                           HSIZE,
  input  wire logic [31:0]                          HWDATA,
  input  wire logic                                 HREADY,
  output logic [31:0]                               HRDATA,
  output logic                                      HREADYOUT,
  output logic                                      HRESP,
  input  wire logic [sink_status_pkg::NUM_STREAMS-1:0] PIXEL_FIFO_OVF,
  input  wire logic [sink_status_pkg::NUM_UNPACK-1:0]  UNPACK_FIFO_OVF,
  input  wire logic [sink_status_pkg::NUM_TIMING-1:0]  TIMING_FIFO_OVF,
  input  wire logic [sink_status_pkg::NUM_STREAMS-1:0] VSYNC_IN,
  output logic                                      IRQ
);
  import sink_status_pkg::*;

  // Event and sync inputs come from other clock domains
  overrun_s                  ovr_raw;
  logic [OVR_W-1:0]          ovr_in;
  logic [OVR_W-1:0]          ovr_s1_r;
  logic [OVR_W-1:0]          ovr_s2_r;
  logic [OVR_W-1:0]          ovr_s3_r;
  logic [NUM_STREAMS-1:0]    vs_s1_r;
  logic [NUM_STREAMS-1:0]    vs_s2_r;

  assign ovr_raw = '{timing: TIMING_FIFO_OVF, unpack: UNPACK_FIFO_OVF, pixel: PIXEL_FIFO_OVF};
  assign ovr_in  = ovr_raw;

  // Two stages per line; the third stage only feeds the edge detector
  genvar gi;
  generate
    for (gi = 0; gi < OVR_W; gi++)
    begin : g_ovr_sync
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          ovr_s1_r[gi] <= 1'b0;
          ovr_s2_r[gi] <= 1'b0;
          ovr_s3_r[gi] <= 1'b0;
        end
        else
        begin
          ovr_s1_r[gi] <= ovr_in[gi];
          ovr_s2_r[gi] <= ovr_s1_r[gi];
          ovr_s3_r[gi] <= ovr_s2_r[gi];
        end
      end
    end
    for (gi = 0; gi < NUM_STREAMS; gi++)
    begin : g_vs_sync
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          vs_s1_r[gi] <= 1'b0;
          vs_s2_r[gi] <= 1'b0;
        end
        else
        begin
          vs_s1_r[gi] <= VSYNC_IN[gi];
          vs_s2_r[gi] <= vs_s1_r[gi];
        end
      end
    end
  endgenerate

  // Rising edge of a synchronised level counts as one overflow event
  logic [OVR_W-1:0] ovr_evt;
  assign ovr_evt = ovr_s2_r & ~ovr_s3_r;

  // AHB address phase capture
  ahb_req_s req_r;
  logic     req_vld_r;
  logic     req_vld_nxt;
  ahb_req_s req_nxt;

  logic     trans_act;
  logic     size_ok;
  logic     wr_ok;

  assign trans_act   = (HTRANS == HTRANS_NONSEQ) || (HTRANS == HTRANS_SEQ);
  // Sub-word writes are dropped rather than merged into a word
  assign size_ok     = (HSIZE == HSIZE_WORD);
  assign wr_ok       = ~HWRITE | size_ok;
  assign req_vld_nxt = HSEL & HREADY & trans_act & wr_ok;
  assign req_nxt     = '{addr: HADDR[ADDR_W-1:0], write: HWRITE};

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      req_vld_r <= 1'b0;
      req_r     <= '0;
    end
    else
    begin
      req_vld_r <= req_vld_nxt;
      if (req_vld_nxt)
        req_r <= req_nxt;
    end
  end

  // Word decode on the bits above the byte lane; upper address bits are ignored
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return (a[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB]);
  endfunction

  // Interrupt registers share the bit layout of the overrun register
  function automatic logic [31:0] ovr_layout(input logic [OVR_W-1:0] v);
    overrun_s    s;
    logic [31:0] w;
    s = v;
    w = ZERO_WORD;
    w[PIX_OVF_LSB    +: NUM_STREAMS] = s.pixel;
    w[UNPACK_OVF_LSB +: NUM_UNPACK]  = s.unpack;
    w[TIMING_OVF_LSB +: NUM_TIMING]  = s.timing;
    return w;
  endfunction

  // Inverse of ovr_layout, so a written bit lands on the flag it lines up with
  function automatic logic [OVR_W-1:0] ovr_unpack(input logic [31:0] w);
    overrun_s s;
    s.pixel  = w[PIX_OVF_LSB    +: NUM_STREAMS];
    s.unpack = w[UNPACK_OVF_LSB +: NUM_UNPACK];
    s.timing = w[TIMING_OVF_LSB +: NUM_TIMING];
    return s;
  endfunction

  // Reads decode in the address phase, writes in the data phase while HWDATA stands
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_req;
  logic              rd_ident;
  logic              rd_overrun;
  logic              rd_vsync;
  logic              rd_istat;
  logic              rd_imask;
  logic              wr_now;
  logic              wr_istat;
  logic              wr_imask;

  assign rd_addr    = HADDR[ADDR_W-1:0];
  assign rd_req     = req_vld_nxt & ~HWRITE;
  assign rd_ident   = rd_req & hit(rd_addr, CORE_IDENT_OFS);
  assign rd_overrun = rd_req & hit(rd_addr, OVERRUN_OFS);
  assign rd_vsync   = rd_req & hit(rd_addr, VSYNC_OFS);
  assign rd_istat   = rd_req & hit(rd_addr, IRQ_STATUS_OFS);
  assign rd_imask   = rd_req & hit(rd_addr, IRQ_MASK_OFS);
  assign wr_now     = req_vld_r & req_r.write;
  assign wr_istat   = wr_now & hit(req_r.addr, IRQ_STATUS_OFS);
  assign wr_imask   = wr_now & hit(req_r.addr, IRQ_MASK_OFS);

  // Synchronised events split by source
  overrun_s                 evt_s;
  logic [NUM_STREAMS-1:0]   pix_flag_r;
  logic [NUM_UNPACK-1:0]    unp_flag_r;
  logic [NUM_TIMING-1:0]    tim_flag_r;
  overrun_s                 flag_s;
  logic [OVR_W-1:0]         ovr_r;

  assign evt_s  = ovr_evt;
  assign flag_s = '{timing: tim_flag_r, unpack: unp_flag_r, pixel: pix_flag_r};
  assign ovr_r  = flag_s;

  // Each flag sets on its event; in the cycle of a clearing read the event wins
  generate
    for (gi = 0; gi < NUM_STREAMS; gi++)
    begin : g_pix_flag
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          pix_flag_r[gi] <= 1'b0;
        end
        else
        begin
          pix_flag_r[gi] <= evt_s.pixel[gi] | (pix_flag_r[gi] & ~rd_overrun);  // see (RL5) (RL6)
        end
      end
    end
    // Unpack and timing flags do not clear on read; they hold until reset
    for (gi = 0; gi < NUM_UNPACK; gi++)
    begin : g_unp_flag
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          unp_flag_r[gi] <= 1'b0;
        end
        else
        begin
          unp_flag_r[gi] <= evt_s.unpack[gi] | unp_flag_r[gi];  // see (RL7)
        end
      end
    end
    for (gi = 0; gi < NUM_TIMING; gi++)
    begin : g_tim_flag
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          tim_flag_r[gi] <= 1'b0;
        end
        else
        begin
          tim_flag_r[gi] <= evt_s.timing[gi] | tim_flag_r[gi];  // see (RL8)
        end
      end
    end
  endgenerate

  // Interrupt status mirrors the same events and clears by writing one
  logic [OVR_W-1:0] wr_bits;
  logic [OVR_W-1:0] istat_r;
  logic [OVR_W-1:0] istat_clr;
  logic [OVR_W-1:0] imask_r;
  logic [OVR_W-1:0] imask_nxt;
  logic             irq_nxt;
  logic             irq_r;

  assign wr_bits   = ovr_unpack(HWDATA);
  assign istat_clr = wr_istat ? wr_bits : '0;
  assign imask_nxt = wr_imask ? wr_bits : imask_r;
  assign irq_nxt   = |(istat_r & imask_r);

  generate
    for (gi = 0; gi < OVR_W; gi++)
    begin : g_istat
      always_ff @(posedge CLOCK or posedge RST)
      begin
        if (RST)
        begin
          istat_r[gi] <= 1'b0;
        end
        else
        begin
          istat_r[gi] <= ovr_evt[gi] | (istat_r[gi] & ~istat_clr[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      imask_r <= '0;
    end
    else
    begin
      imask_r <= imask_nxt;
    end
  end

  // Registered so the pin never glitches while status and mask change together
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  // Identity fields
  logic [7:0]             ident_major;
  logic [7:0]             ident_minor;
  logic [7:0]             ident_rev;
  logic [7:0]             ident_mode;
  logic [NUM_STREAMS-1:0] vs_live;
  logic [31:0]            ident_word;
  logic [31:0]            overrun_word;
  logic [31:0]            vsync_word;
  logic [31:0]            istat_word;
  logic [31:0]            imask_word;
  logic [31:0]            hrdata_nxt;
  logic [31:0]            hrdata_r;

  assign ident_major  = PROTO_MAJOR;  // see (RL1)
  assign ident_minor  = PROTO_MINOR;
  assign ident_rev    = PROTO_REV;
  assign ident_mode   = MODE_RECEIVE;  // see (RL2)
  assign ident_word   = (32'(ident_major) << IDENT_MAJ_LSB) | (32'(ident_minor) << IDENT_MIN_LSB) |
                        (32'(ident_rev) << IDENT_REV_LSB) | 32'(ident_mode);
  assign vs_live      = vs_s2_r;
  assign overrun_word = ovr_layout(ovr_r);  // see (RL4) (RL10)
  assign vsync_word   = ZERO_WORD | (32'(vs_live) << VSYNC_LSB);  // see (RL9) (RL10)
  assign istat_word   = ovr_layout(istat_r);
  assign imask_word   = ovr_layout(imask_r);

  // Read data is taken at the address edge so a flop drives it through the data phase.
  // The read-clear lands on that same edge, so no event slips between capture and clear.
  // Limitation: a read right behind a write to the same word returns the value before it.
  assign hrdata_nxt = rd_ident   ? ident_word   :  // see (RL3)
                      rd_overrun ? overrun_word :
                      rd_vsync   ? vsync_word   :
                      rd_istat   ? istat_word   :
                      rd_imask   ? imask_word   :
                                   ZERO_WORD;  // see (RL10)

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      hrdata_r <= ZERO_WORD;
    end
    else
    begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // Zero wait states, no error response; writes to read-only words are dropped
  assign HRDATA    = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign IRQ       = irq_r;

endmodule
`default_nettype wire

// *** sink_id_and_overflow_status_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sink_id_and_overflow_status_regs_tb;
  import sink_status_pkg::*;
  logic        clk, rst, sel, hw, rdy, resp, irq;
  logic [1:0]  tr;
  logic [2:0]  unp, tim;
  logic [3:0]  pix, vs;
  logic [31:0] ad, wd, rd, q;
  int          error_cnt, total_checks;
  sink_id_and_overflow_status_regs uut (.CLOCK(clk), .RST(rst), .HSEL(sel), .HADDR(ad), .HTRANS(tr),
    .HWRITE(hw), .HSIZE(HSIZE_WORD), .HWDATA(wd), .HREADY(rdy), .HRDATA(rd), .HREADYOUT(rdy),
    .HRESP(resp), .PIXEL_FIFO_OVF(pix), .UNPACK_FIFO_OVF(unp), .TIMING_FIFO_OVF(tim), .VSYNC_IN(vs), .IRQ(irq));
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    sel <= 1'b1;
    tr  <= HTRANS_NONSEQ;
    ad  <= {20'h0_0000, a};
    hw  <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 1'b0;
    tr  <= 2'h0;
    wd  <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rd;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task t_id;
    xf(1'b1, CORE_IDENT_OFS, 32'hFFFF_FFFF);
    xf(1'b0, CORE_IDENT_OFS, ZERO_WORD);
    chk("ident", 32'h0100_0001, q);
    xf(1'b0, 12'h200, ZERO_WORD);
    chk("unmapped", ZERO_WORD, q);
  endtask
  task t_ovf;
    pix <= 4'h9;
    unp <= 3'h5;
    tim <= 3'h7;
    repeat (2) @(posedge clk);
    {pix, unp, tim} <= 10'h000;
    repeat (5) @(posedge clk);
    xf(1'b1, OVERRUN_OFS, 32'hFFFF_FFFF);
    xf(1'b0, OVERRUN_OFS, ZERO_WORD);
    chk("overrun", 32'h0000_0E59, q);
    xf(1'b0, OVERRUN_OFS, ZERO_WORD);
    chk("overrun after read", 32'h0000_0E50, q);
  endtask
  task t_vs;
    for (int i = 0; i < 2; i++)
    begin
      vs <= i ? 4'h5 : 4'hA;
      repeat (3) @(posedge clk);
      xf(1'b0, VSYNC_OFS, ZERO_WORD);
      chk("vsync", i ? 32'h0000_0005 : 32'h0000_000A, q);
    end
  endtask
  // Stream one pixel event is still pending in the interrupt status
  task t_irq;
    chk("irq masked", ZERO_WORD, {31'h0, irq});
    xf(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    xf(1'b1, IRQ_STATUS_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", ZERO_WORD, {31'h0, irq});
    xf(1'b1, IRQ_MASK_OFS, 32'hFFFF_FFFF);
    xf(1'b0, IRQ_MASK_OFS, ZERO_WORD);
    chk("irq mask", 32'h0000_0E7F, q);
    xf(1'b0, IRQ_STATUS_OFS, ZERO_WORD);
    chk("irq status", 32'h0000_0E58, q);
    chk("irq timing", 32'h0000_0001, {31'h0, irq});
  endtask
  task close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {sel, hw, tr, ad, wd, pix, unp, tim, vs} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_id;
    t_ovf;
    t_vs;
    t_irq;
    close_out;
  end
  initial
  begin
    repeat (600) @(posedge clk);
    error_cnt++;
    close_out;
  end
endmodule
bind sink_id_and_overflow_status_regs sink_status_checker chk_i (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HREADY(HREADY), .HWRITE(HWRITE), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .PIXEL_FIFO_OVF(PIXEL_FIFO_OVF), .VSYNC_IN(VSYNC_IN));
`default_nettype wire

// *** sink_status_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sink_status_checker (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HREADY,
  input wire logic        HWRITE,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [3:0]  PIXEL_FIFO_OVF,
  input wire logic [3:0]  VSYNC_IN
);
  import sink_status_pkg::*;
  wire logic [9:0] wa     = HADDR[11:2];
  wire logic       rd     = HSEL && HREADY && HTRANS[1] && !HWRITE;
  wire logic       rd_ovf = rd && wa == OVERRUN_OFS[11:2];
  wire logic       rd_vs  = rd && wa == VSYNC_OFS[11:2];
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  a_ready_high: assert property (HREADYOUT) else $error("ready low");
  a_resp_okay: assert property (!HRESP) else $error("bad response");
  a_id_mode: assert property (rd && wa == 10'h03F |=> HRDATA[7:0] == MODE_RECEIVE)
    else $error("mode byte");
  a_ovf_spare: assert property (rd_ovf |=> {HRDATA[31:12], HRDATA[8:7]} == 22'h00_0000)
    else $error("overrun spare bits");
  a_vs_spare: assert property (rd_vs |=> HRDATA[31:4] == 28'h000_0000)
    else $error("vsync spare bits");
  a_vs_live: assert property (rd_vs && $stable(VSYNC_IN) && $past(VSYNC_IN, 2) == VSYNC_IN
    |=> HRDATA[3:0] == $past(VSYNC_IN)) else $error("vsync state");
  // Five quiet samples rule out a late event beating the clear
  a_pix_clear: assert property (rd_ovf ##2 rd_ovf && !(PIXEL_FIFO_OVF | $past(PIXEL_FIFO_OVF)
    | $past(PIXEL_FIFO_OVF, 2) | $past(PIXEL_FIFO_OVF, 3) | $past(PIXEL_FIFO_OVF, 4)) |=> !HRDATA[3:0])
    else $error("pixel flag kept");
  a_unmap_zero: assert property (rd && !(wa inside {10'h03F, 10'h044, 10'h045, 10'h048, 10'h049})
    |=> HRDATA == ZERO_WORD) else $error("unmapped data");
  c_ovf_twice: cover property (rd_ovf ##2 rd_ovf);
  c_vs_read: cover property (rd_vs);
  c_id_read: cover property (rd && wa == 10'h03F);
endmodule
`default_nettype wire

// *** sink_status_pkg.sv ***
`default_nettype none
package sink_status_pkg;

  localparam logic [11:0] CORE_IDENT_OFS  = 12'h0_0FC;
  localparam logic [11:0] OVERRUN_OFS     = 12'h0_110;
  localparam logic [11:0] VSYNC_OFS       = 12'h0_114;
  localparam logic [11:0] IRQ_STATUS_OFS  = 12'h0_120;
  localparam logic [11:0] IRQ_MASK_OFS    = 12'h0_124;

  localparam int ADDR_W   = 12;
  localparam int WORD_LSB = 2;

  localparam int NUM_STREAMS  = 4;
  localparam int NUM_UNPACK   = 3;
  localparam int NUM_TIMING   = 3;

  localparam int PIX_OVF_LSB    = 0;
  localparam int UNPACK_OVF_LSB = 4;
  localparam int TIMING_OVF_LSB = 9;
  localparam int VSYNC_LSB      = 0;
  localparam int IDENT_MAJ_LSB  = 24;
  localparam int IDENT_MIN_LSB  = 16;
  localparam int IDENT_REV_LSB  = 8;

  localparam logic [7:0] MODE_TRANSMIT = 8'h00;
  localparam logic [7:0] MODE_RECEIVE  = 8'h01;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Overrun events, one bit per FIFO source
  typedef struct packed {
    logic [NUM_TIMING-1:0]  timing;
    logic [NUM_UNPACK-1:0]  unpack;
    logic [NUM_STREAMS-1:0] pixel;
  } overrun_s;

  localparam int OVR_W = NUM_STREAMS + NUM_UNPACK + NUM_TIMING;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
  } ahb_req_s;

endpackage
`default_nettype wire
